// ===== src/pmb_mem_port.sv
// Purpose: external program memory port with address pin straps
// Assumes: cpu side and power bits run on clk_sys; pins are async
// Notes:   address bit 2 and low address drivers stay off until the straps are latched
//
// How it works
// R1: external bus moves bytes only when select is 0
// R2: upper and low address pins carry byte address
// R3: address bit 2 is pulled-down mode strap in reset
// R4: release latches mode, drops pull-down, drives pin
// R5: mode 0 crystal 24 MHz, 1 external clock
// R6: external mode floats bit 2 while sleeping
// R7: crystal mode drives bit 2 like upper address
// R8: low address bits are pulled-down frequency straps
// R9: frequency 00 is 24, 11 is 48 MHz
// R10: low bits strapped 1 float while sleeping
// R11: program memory select latched at reset release
// R12: active-low read strobe on each read
// R13: active-low write strobe on each write
// R14: chip enable active low, high during reset
// R15: 48 MHz only counts in external clock mode
// R16: latched straps stay fixed until next reset
`timescale 1ns/1ps
module pmb_mem_port #(
  parameter int STROBE_LEN = pmb_pkg::STROBE_CYCLES  // strobe cycles
) (
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  input  wire logic                       clk_en,
  // cpu side
  input  wire logic                       cpu_req,
  input  wire logic                       cpu_write,
  input  wire logic [pmb_pkg::ADDR_W-1:0] cpu_addr,
  input  wire logic [pmb_pkg::DATA_W-1:0] cpu_wdata,
  output logic                            cpu_ready,
  output logic                            cpu_done,
  output logic      [pmb_pkg::DATA_W-1:0] cpu_rdata,
  // power state bits
  input  wire logic                       cpu_idle,
  input  wire logic                       interrupt_two,
  input  wire logic                       clock_sel_sleep,
  // memory pins
  input  wire logic [pmb_pkg::DATA_W-1:0] prog_mem_data_bus_in,
  output logic      [pmb_pkg::DATA_W-1:0] prog_mem_data_bus_out,
  output logic                            prog_mem_data_bus_oe,
  output logic [pmb_pkg::ADDR_W-1:pmb_pkg::UPPER_LSB]
                                          prog_mem_upper_address,
  input  wire logic                       prog_mem_address_bit2_in,
  output logic                            prog_mem_address_bit2_out,
  output logic                            prog_mem_address_bit2_oe,
  input  wire logic [pmb_pkg::LOW_W-1:0]  prog_mem_low_address_in,
  output logic      [pmb_pkg::LOW_W-1:0]  prog_mem_low_address_out,
  output logic      [pmb_pkg::LOW_W-1:0]  prog_mem_low_address_oe,
  output logic                            strap_pulldown_en,
  input  wire logic                       general_pin_six_in,
  output logic                            select_pullup_en,
  output logic                            prog_mem_read_strobe_n,
  output logic                            prog_mem_write_strobe_n,
  output logic                            prog_mem_chip_enable_n,
  // latched strap status
  output logic                            internal_program_memory_select,
  output logic                            clock_mode_strap,
  output logic      [pmb_pkg::LOW_W-1:0]  clock_freq_strap,
  output logic                            ext_clock_48mhz,
  output logic                            freq_strap_reserved,
  output logic                            straps_valid
);
  // -----------------------------------------------------------------
  // declarations
  // -----------------------------------------------------------------
  localparam int CNT_W = $clog2(STROBE_LEN + 1);  // strobe counter width

  logic [pmb_pkg::STRAP_W-1:0] strap_pins;      // raw strap pins
  logic [pmb_pkg::STRAP_W-1:0] strap_value;     // latched straps
  logic                        strap_done;      // straps are latched
  logic                        sleep_cond;      // power-down condition
  pmb_pkg::pmb_state_e         state;           // access sequencer
  logic [CNT_W-1:0]            cnt;             // strobe cycle counter
  logic                        we;              // access is a write
  logic [pmb_pkg::ADDR_W-1:0]  addr;            // address register
  logic [pmb_pkg::DATA_W-1:0]  data_a;          // data sync, first stage
  logic [pmb_pkg::DATA_W-1:0]  data_b;          // data sync, second stage

  generate
    if (STROBE_LEN < 1 || STROBE_LEN >= (1 << 8)) begin : g_bad_len
      $error("pmb_mem_port: STROBE_LEN must be 1 to 255");
    end
  endgenerate

  // -----------------------------------------------------------------
  // strap capture
  // -----------------------------------------------------------------
  // mode and frequency pins are read back through the same pads the address drives
  assign strap_pins = {general_pin_six_in, prog_mem_address_bit2_in,
                       prog_mem_low_address_in};

  pmb_strap_latch #(
    .W           (pmb_pkg::STRAP_W)
  ) u_strap (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .clk_en      (clk_en),
    .strap_pin   (strap_pins),
    .strap_value (strap_value),
    .strap_done  (strap_done)
  );

  // status views of the latched straps
  assign internal_program_memory_select =
    strap_value[pmb_pkg::STRAP_INTERNAL_PROGRAM_MEMORY_SELECT];          // [R11]
  assign clock_mode_strap = strap_value[pmb_pkg::MODE_BIT];  // [R5]
  assign clock_freq_strap = strap_value[pmb_pkg::LOW_W-1:0];
  assign straps_valid     = strap_done;
  // 48 MHz only with external clock, else assume 24 MHz crystal
  assign ext_clock_48mhz = (clock_mode_strap == pmb_pkg::MODE_EXTCLK) &&
                           (clock_freq_strap == pmb_pkg::FREQ_48M);
                                                // [R5] [R9] [R15]
  // codes other than 00 and 11 are flagged, board must not use them
  assign freq_strap_reserved = strap_done &&
    (clock_freq_strap != pmb_pkg::FREQ_24M) &&
    (clock_freq_strap != pmb_pkg::FREQ_48M);    // [R9]

  // -----------------------------------------------------------------
  // pad control
  // -----------------------------------------------------------------
  assign sleep_cond = cpu_idle && !interrupt_two && clock_sel_sleep;

  // pulls on while straps are being sampled
  assign strap_pulldown_en = !strap_done;       // [R3] [R4] [R8]
  assign select_pullup_en  = !strap_done;

  // once straps are latched, bit 2 floats only in external clock mode while sleeping
  assign prog_mem_address_bit2_oe = strap_done &&
    !(clock_mode_strap && sleep_cond);          // [R6] [R7]
  assign prog_mem_address_bit2_out = addr[pmb_pkg::MODE_BIT];  // [R2]

  // each low bit strapped 1 floats while sleeping
  genvar gi;
  generate
    for (gi = 0; gi < pmb_pkg::LOW_W; gi++) begin : g_low
      assign prog_mem_low_address_oe[gi] = strap_done &&
        !(clock_freq_strap[gi] && sleep_cond);  // [R10]
      assign prog_mem_low_address_out[gi] = addr[gi];  // [R2]
    end
  endgenerate

  assign prog_mem_upper_address =
    addr[pmb_pkg::ADDR_W-1:pmb_pkg::UPPER_LSB];  // [R2]

  // chip enable low unless sleeping, high through reset
  assign prog_mem_chip_enable_n = !(strap_done && !sleep_cond);  // [R14]

  // -----------------------------------------------------------------
  // strobes and handshake
  // -----------------------------------------------------------------
  assign prog_mem_read_strobe_n =
    !((state == pmb_pkg::PMB_STROBE) && !we);   // [R12]
  assign prog_mem_write_strobe_n =
    !((state == pmb_pkg::PMB_STROBE) && we);    // [R13]
  assign prog_mem_data_bus_oe = we && (state != pmb_pkg::PMB_IDLE);
  // external bus serves only when internal memory is not selected
  assign cpu_ready = (state == pmb_pkg::PMB_IDLE) && strap_done &&
    !internal_program_memory_select && !sleep_cond;  // [R1]

  // -----------------------------------------------------------------
  // access sequencer
  // -----------------------------------------------------------------
  // setup one cycle, strobe STROBE_LEN cycles, hold one cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= pmb_pkg::PMB_IDLE;
      cnt   <= '0;
    end else if (clk_en) begin
      case (state)
        pmb_pkg::PMB_IDLE: begin
          if (cpu_req && cpu_ready) begin       // [R1]
            state <= pmb_pkg::PMB_SETUP;
          end
        end
        pmb_pkg::PMB_SETUP: begin
          state <= pmb_pkg::PMB_STROBE;
          cnt   <= CNT_W'(STROBE_LEN - 1);
        end
        pmb_pkg::PMB_STROBE: begin
          if (cnt == '0) begin
            state <= pmb_pkg::PMB_HOLD;
          end else begin
            cnt <= cnt - CNT_W'(1);
          end
        end
        default: begin                          // hold
          state <= pmb_pkg::PMB_IDLE;
        end
      endcase
    end
  end

  // address, direction and write data taken with the request
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      addr                  <= '0;
      we                    <= 1'h0;
      prog_mem_data_bus_out <= '0;
    end else if (clk_en && state == pmb_pkg::PMB_IDLE &&
                 cpu_req && cpu_ready) begin
      addr                  <= cpu_addr;        // [R2]
      we                    <= cpu_write;
      prog_mem_data_bus_out <= cpu_wdata;       // [R1] [R13]
    end
  end

  // read data pass two flip-flops before capture
  always_ff @(posedge clk_sys) begin
    if (clk_en) begin
      data_a <= prog_mem_data_bus_in;
      data_b <= data_a;
    end
  end

  // capture read data at end of strobe, pulse done in hold
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cpu_rdata <= '0;
      cpu_done  <= 1'h0;
    end else if (clk_en) begin
      cpu_done <= (state == pmb_pkg::PMB_STROBE) && (cnt == '0);
      if (state == pmb_pkg::PMB_STROBE && cnt == '0 && !we) begin
        cpu_rdata <= data_b;                    // [R1] [R12]
      end
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n || !clk_en);

  sequence s_rd_start;
    cpu_req && cpu_ready && !cpu_write;
  endsequence
  sequence s_wr_start;
    cpu_req && cpu_ready && cpu_write;
  endsequence

  chk_ce_in_reset: assert property (          // [R14]
    !strap_done |-> prog_mem_chip_enable_n && strap_pulldown_en)
    else $error("chip enable or pull low before straps latched");
  chk_no_drive_early: assert property (       // [R3]
    !strap_done |-> !prog_mem_address_bit2_oe &&
                    (prog_mem_low_address_oe == '0))
    else $error("address pins driven before straps latched");
  chk_bit2_float: assert property (           // [R6]
    strap_done && clock_mode_strap && sleep_cond
      |-> !prog_mem_address_bit2_oe)
    else $error("bit 2 driven while sleeping in external mode");
  chk_bit2_follow: assert property (          // [R7]
    strap_done && !clock_mode_strap |-> prog_mem_address_bit2_oe)
    else $error("bit 2 released in crystal mode");
  chk_low_float: assert property (            // [R10]
    strap_done && sleep_cond
      |-> (prog_mem_low_address_oe & clock_freq_strap) == '0)
    else $error("low bit strapped 1 driven while sleeping");
  chk_strap_stable: assert property (         // [R16]
    strap_done && $past(strap_done) |-> $stable(strap_value))
    else $error("latched straps changed");
  chk_internal_refuse: assert property (      // [R1]
    internal_program_memory_select |-> !cpu_ready)
    else $error("external access offered with internal memory");
  chk_upper_addr: assert property (           // [R2]
    s_rd_start |=> prog_mem_upper_address ==
                   $past(cpu_addr[pmb_pkg::ADDR_W-1:pmb_pkg::UPPER_LSB]))
    else $error("upper address not the requested address");
  chk_read_seq: assert property (             // [R12]
    s_rd_start |=> prog_mem_read_strobe_n ##1 !prog_mem_read_strobe_n
                   ##[1:255] cpu_done)
    else $error("read strobe or done out of order");
  chk_write_seq: assert property (            // [R13]
    s_wr_start |=> prog_mem_data_bus_oe ##1
                   (!prog_mem_write_strobe_n && prog_mem_data_bus_oe))
    else $error("write strobe or data drive missing");
  chk_48m_mode: assert property (             // [R15]
    ext_clock_48mhz |-> clock_mode_strap && clock_freq_strap[0])
    else $error("48 MHz flagged without external clock mode");
endmodule : pmb_mem_port

// ===== src/pmb_pkg.sv
// Purpose: shared constants and types of the program memory bus port
// Assumes: core clock of 40 MHz
// Notes:   pin positions, strap codes and access timing live here
package pmb_pkg;
  // -----------------------------------------------------------------
  // widths and pin positions
  // -----------------------------------------------------------------
  localparam int ADDR_W       = 16;            // byte address width
  localparam int DATA_W       = 8;             // memory data bus width
  localparam int UPPER_LSB    = 3;             // lowest upper address bit
  localparam int MODE_BIT     = 2;             // address bit with mode strap
  localparam int LOW_W        = 2;             // frequency strap width
  localparam int STRAP_W      = 4;             // internal_program_memory_select + mode + frequency
  localparam int STRAP_INTERNAL_PROGRAM_MEMORY_SELECT  = 3;             // strap vector position
  localparam int SYNC_STAGES  = 2;             // pin synchroniser depth

  // -----------------------------------------------------------------
  // strap codes
  // -----------------------------------------------------------------
  localparam logic [1:0] FREQ_24M    = 2'h0;   // 24 MHz
  localparam logic [1:0] FREQ_48M    = 2'h3;   // 48 MHz
  localparam logic       MODE_XTAL   = 1'h0;   // crystal, 24 MHz only
  localparam logic       MODE_EXTCLK = 1'h1;   // external clock source

  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 25;          // 40 MHz core clock
  localparam int ACCESS_TIME_NS = 100;         // least memory access time
  localparam int ACCESS_CYCLES  =
    (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // strobe covers access time plus the read data synchroniser
  localparam int STROBE_CYCLES  = ACCESS_CYCLES + SYNC_STAGES;

  // -----------------------------------------------------------------
  // access sequencer states
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    PMB_IDLE,
    PMB_SETUP,
    PMB_STROBE,
    PMB_HOLD
  } pmb_state_e;
endpackage : pmb_pkg

// ===== src/pmb_strap_latch.sv
// Purpose: synchronise strap pins and latch them once after reset
// Assumes: pins are driven only by board pulls while reset is held
// Notes:   synchroniser has no reset so it tracks the pins during reset
`timescale 1ns/1ps
module pmb_strap_latch #(
  parameter int W = 4                           // number of straps
) (
  input  wire logic         clk_sys,            // core clock
  input  wire logic         rst_n,              // async reset, active low
  input  wire logic         clk_en,             // freezes state when low
  input  wire logic [W-1:0] strap_pin,          // raw strap pins
  output logic      [W-1:0] strap_value,        // latched strap values
  output logic              strap_done          // straps latched
);
  // -----------------------------------------------------------------
  // synchroniser and capture
  // -----------------------------------------------------------------
  logic [W-1:0] sync_a;                         // first stage, only to sync_b
  logic [W-1:0] sync_b;                         // second stage

  generate
    if (W < 1) begin : g_bad_w
      $error("pmb_strap_latch: W must be at least 1");
    end
  endgenerate

  // two flip-flops keep running while reset is held
  always_ff @(posedge clk_sys) begin
    if (clk_en) begin
      sync_a <= strap_pin;
      sync_b <= sync_a;
    end
  end

  // first enabled edge after release takes the straps and holds them
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      strap_value <= '0;
      strap_done  <= 1'h0;
    end else if (clk_en && !strap_done) begin   // [R4] [R8] [R11]
      strap_value <= sync_b;
      strap_done  <= 1'h1;                      // [R16]
    end
  end
endmodule : pmb_strap_latch

// ===== dv/pmb_ext_mem.sv
// Purpose: behavioural external program memory on the memory pins
// Assumes: byte wide, enabled by the active-low chip enable
// Notes:   answers LAT cycles after the read strobe falls; the data
//          bus floats to its pull-up level when nobody drives it
`timescale 1ns/1ps
module pmb_ext_mem #(
  parameter int LAT = 1                    // read answer delay
) (
  input  wire logic        clk_sys,        // core clock
  input  wire logic [15:0] addr,           // resolved address pins
  input  wire logic [7:0]  dut_data,       // data driven by the port
  input  wire logic        dut_oe,         // port drives data bus
  input  wire logic        rd_n,           // read strobe, active low
  input  wire logic        wr_n,           // write strobe, active low
  input  wire logic        ce_n,           // chip enable, active low
  output logic      [7:0]  data_pad,       // resolved data bus level
  output logic      [15:0] last_addr       // address of last strobe
);
  // -----------------------------------------------------------------
  // storage and strobe tracking
  // -----------------------------------------------------------------
  logic [7:0] mem [0:65535];               // memory cells
  int         rd_cnt;                      // cycles read strobe low

  // counts read time, stores written bytes, notes the address
  always_ff @(posedge clk_sys) begin
    if (!ce_n && !rd_n) rd_cnt <= rd_cnt + 1;
    else rd_cnt <= 0;
    if (!ce_n && (!rd_n || !wr_n)) last_addr <= addr;
    if (!ce_n && !wr_n && dut_oe) mem[addr] <= dut_data;
  end

  // bus level: port, memory after its access time, else pull-ups
  always_comb begin
    if (dut_oe) data_pad = dut_data;
    else if (!ce_n && !rd_n && rd_cnt >= LAT) data_pad = mem[addr];
    else data_pad = 8'hFF;
  end
endmodule : pmb_ext_mem

// ===== dv/test_ext_program_memory_bus_straps.sv
// Purpose: self-checking bench of the program memory port
// Assumes: 40 MHz clock, board straps set per reset
// Notes:   short strobe length keeps accesses brief
`timescale 1ns/1ps
module test_ext_program_memory_bus_straps;
  // -----------------------------------------------------------------
  // signals
  // -----------------------------------------------------------------
  localparam int SL = 4;                   // strobe cycles used
  logic clk_sys, rst_n, clk_en, cpu_req, cpu_write, cpu_ready, cpu_done;
  logic [15:0] cpu_addr, mem_addr, last_addr;
  logic [7:0]  cpu_wdata, cpu_rdata, d_out, d_pad;
  logic [15:3] up_addr;                    // upper address pins
  logic        d_oe, a2_out, a2_oe, a2_pin, pd_en, pu_en, rd_n, wr_n;
  logic [1:0]  lo_out, lo_oe, freq;
  wire  [1:0]  lo_pin;                     // resolved low address pins
  logic        ce_n, sel, mode, ext48, resv, valid, brd_sel;
  logic        cpu_idle, interrupt_two, clock_sel_sleep;
  logic [2:0]  brd;                        // board pull-ups on bits 2..0
  int          n_mismatch = 0;
  int          checks_done = 0;

  // undriven strap pins: board pull-up, else pull-down, else float
  assign a2_pin = a2_oe ? a2_out : brd[2] ? 1'b1 : pd_en ? 1'b0 : ~a2_out;
  assign lo_pin[1] = lo_oe[1] ? lo_out[1] : brd[1] ? 1'b1 :
                     pd_en ? 1'b0 : ~lo_out[1];
  assign lo_pin[0] = lo_oe[0] ? lo_out[0] : brd[0] ? 1'b1 :
                     pd_en ? 1'b0 : ~lo_out[0];
  assign mem_addr = {up_addr, a2_pin, lo_pin};

  pmb_mem_port #(.STROBE_LEN(SL)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
    .cpu_req(cpu_req), .cpu_write(cpu_write), .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata), .cpu_ready(cpu_ready), .cpu_done(cpu_done),
    .cpu_rdata(cpu_rdata), .cpu_idle(cpu_idle),
    .interrupt_two(interrupt_two), .clock_sel_sleep(clock_sel_sleep),
    .prog_mem_data_bus_in(d_pad), .prog_mem_data_bus_out(d_out),
    .prog_mem_data_bus_oe(d_oe), .prog_mem_upper_address(up_addr),
    .prog_mem_address_bit2_in(a2_pin), .prog_mem_address_bit2_out(a2_out),
    .prog_mem_address_bit2_oe(a2_oe), .prog_mem_low_address_in(lo_pin),
    .prog_mem_low_address_out(lo_out), .prog_mem_low_address_oe(lo_oe),
    .strap_pulldown_en(pd_en), .general_pin_six_in(brd_sel),
    .select_pullup_en(pu_en), .prog_mem_read_strobe_n(rd_n),
    .prog_mem_write_strobe_n(wr_n), .prog_mem_chip_enable_n(ce_n),
    .internal_program_memory_select(sel), .clock_mode_strap(mode),
    .clock_freq_strap(freq), .ext_clock_48mhz(ext48),
    .freq_strap_reserved(resv), .straps_valid(valid));

  pmb_ext_mem #(.LAT(1)) mem (
    .clk_sys(clk_sys), .addr(mem_addr), .dut_data(d_out), .dut_oe(d_oe),
    .rd_n(rd_n), .wr_n(wr_n), .ce_n(ce_n), .data_pad(d_pad),
    .last_addr(last_addr));

  // -----------------------------------------------------------------
  // tasks
  // -----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  // hold reset 20 cycles with given board straps, then release
  task automatic do_reset(input logic [2:0] b, input logic s);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    brd <= b;
    brd_sel <= s;
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("ce_n in reset", ce_n, 16'h1);
    chk("pulls in reset", {pd_en, pu_en}, 16'h3);
    chk("a2 oe in reset", a2_oe, 16'h0);
    chk("low oe in reset", lo_oe, 16'h0);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("pulls off", {pd_en, pu_en, valid}, 16'h1);
    chk("a2 oe", a2_oe, 16'h1);
    chk("low oe", lo_oe, 16'h3);
  endtask : do_reset

  // sleep is idle bit set, interrupt two low, sleep bit set
  task automatic set_sleep(input logic s);
    @(posedge clk_sys);
    cpu_idle <= s;
    interrupt_two <= 1'b0;
    clock_sel_sleep <= s;
    @(negedge clk_sys);
  endtask : set_sleep

  // one byte access; checks latency, address pins and read data
  task automatic access(input logic w, input logic [15:0] a,
                        input logic [7:0] d);
    int n;
    n = 0;
    while (cpu_ready !== 1'b1 && n < 50) begin
      @(negedge clk_sys);
      n++;
    end
    @(posedge clk_sys);
    cpu_req <= 1'b1;
    cpu_write <= w;
    cpu_addr <= a;
    cpu_wdata <= d;
    @(posedge clk_sys);
    cpu_req <= 1'b0;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (cpu_done !== 1'b1 && n < 50);
    chk("done latency", 16'(n), 16'(SL + 2));
    chk("address pins", last_addr, a);
    if (!w) chk("read data", cpu_rdata, d);
  endtask : access

  // -----------------------------------------------------------------
  // clock, watchdog and test sequence
  // -----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // cut a hang short well past the expected few hundred cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_mismatch++;
    end_of_test();
  end

  initial begin
    {rst_n, clk_en, cpu_req, cpu_write, cpu_idle} = 5'h08;
    {interrupt_two, clock_sel_sleep, brd_sel} = 3'h0;
    {cpu_addr, cpu_wdata, brd} = '0;
    // crystal mode, external program memory
    do_reset(3'h0, 1'b0);
    chk("select", sel, 16'h0);
    chk("mode", {mode, freq, ext48}, 16'h0);
    access(1'b1, 16'hA5C7, 8'h3C);
    access(1'b0, 16'hA5C7, 8'h3C);
    set_sleep(1'b1);
    chk("crystal a2 oe", {a2_oe, lo_oe}, 16'h7);
    chk("ready asleep", cpu_ready, 16'h0);
    set_sleep(1'b0);
    // external clock mode with every frequency code
    for (int f = 0; f < 4; f++) begin
      do_reset({1'b1, 2'(f)}, 1'b0);
      chk("ext mode", mode, 16'h1);
      chk("freq", freq, 16'(f));
      chk("48 MHz", ext48, 16'(f == 3));
      chk("reserved", resv, 16'(f == 1 || f == 2));
      set_sleep(1'b1);
      chk("a2 float", {a2_oe, ce_n}, 16'h1);
      chk("low float", lo_oe, 16'(~f & 3));
      set_sleep(1'b0);
      chk("a2 awake", {a2_oe, lo_oe}, 16'h7);
    end
    // interrupt two raised: not asleep, so pins stay driven
    @(posedge clk_sys);
    {cpu_idle, interrupt_two, clock_sel_sleep} <= 3'h7;
    @(negedge clk_sys);
    chk("awake on interrupt_two", {a2_oe, lo_oe, ce_n}, 16'hE);
    set_sleep(1'b0);
    access(1'b1, 16'h5A38, 8'hC3);
    access(1'b0, 16'h5A38, 8'hC3);
    chk("straps kept", {mode, freq}, 16'h7);
    // 48 MHz code ignored in crystal mode
    do_reset(3'h3, 1'b0);
    chk("crystal 48", {mode, ext48}, 16'h0);
    // internal program memory selected: requests refused
    do_reset(3'h0, 1'b1);
    chk("select", sel, 16'h1);
    begin
      int n;
      n = 0;
      @(posedge clk_sys);
      cpu_req <= 1'b1;
      cpu_write <= 1'b0;
      repeat (10) begin
        @(negedge clk_sys);
        if (cpu_done !== 1'b0 || rd_n !== 1'b1) n++;
      end
      @(posedge clk_sys);
      cpu_req <= 1'b0;
      chk("refused", 16'(n), 16'h0);
    end
    end_of_test();
  end
endmodule : test_ext_program_memory_bus_straps
